// ===== ssom_capture.sv
`timescale 1ns/1ns
module ssom_capture (
  input wire logic                  pixel_output_clock,
  input wire ssom_pkg::ssom_pixel_t   port_a,
  input wire ssom_pkg::ssom_lane_oe_t port_a_oe,
  input wire ssom_pkg::ssom_pixel_t   port_b,
  input wire ssom_pkg::ssom_lane_oe_t port_b_oe,
  output ssom_pkg::ssom_pixel_t       cap_a,
  output ssom_pkg::ssom_pixel_t       cap_b,
  output int                        caps
);
  import ssom_pkg::*;
  // Undriven lanes float: show the inverse of the last value seen
  function automatic ssom_pixel_t seen(ssom_pixel_t d, ssom_lane_oe_t oe,
                                       ssom_pixel_t prev);
    seen.r = oe.r ? d.r : ~prev.r;
    seen.g = oe.g ? d.g : ~prev.g;
    seen.b = oe.b ? d.b : ~prev.b;
  endfunction
  initial begin
    cap_a = '0;
    cap_b = '0;
    caps = 0;
  end
  always @(posedge pixel_output_clock) begin
    cap_a <= seen(port_a, port_a_oe, cap_a);
    cap_b <= seen(port_b, port_b_oe, cap_b);
    caps <= caps + 1;
  end
endmodule

// ===== ssom_chk_asserts.sv
`timescale 1ns/1ns
module ssom_chk #(
  parameter int ACTIVITY_TIMEOUT = 64
) (
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [2:0]            hsize,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic [3:0]            sync_inputs,
  input wire ssom_pkg::ssom_pixel_t   pixel_in,
  input wire logic                  pixel_valid,
  input wire ssom_pkg::ssom_pixel_t   port_a,
  input wire ssom_pkg::ssom_lane_oe_t port_a_oe,
  input wire ssom_pkg::ssom_lane_oe_t port_b_oe,
  input wire logic                  pixel_output_clock,
  input wire logic                  active_line_sync_source,
  input wire logic                  active_frame_sync_source,
  input wire logic                  analog_channel_select,
  input wire logic [1:0]            analog_bandwidth_code,
  input wire logic                  external_pixel_clock_select
);
  import ssom_pkg::*;
  // ========================================
  // Shadow of the bus and the writable bytes
  // ========================================
  logic        take;     // Address phase accepted
  logic        hit;      // Mapped word address
  logic        dp_rd;    // Read data phase
  logic        dp_wr;    // Write data phase
  logic        dp_hit;   // Data phase address was mapped
  logic [7:0]  dp_idx;   // Data phase register index
  logic [7:0]  exp_mode; // Expected mode byte
  logic [7:0]  exp_ctrl; // Expected sync control byte
  logic [1:0]  mode_age; // Cycles since mode write, saturating
  logic [1:0]  ctrl_age; // Cycles since control write, saturating
  logic        frame_q;  // Frame pin one cycle ago
  int          quiet;    // Cycles without a frame pin change
  ssom_pixel_t last_pix; // Last sample taken
  assign take = hsel && hready && htrans == HTRANS_NONSEQ
                && hsize == HSIZE_WORD;
  assign hit = haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0
               && (haddr[9:2] == IDX_SYNC_CTRL || haddr[9:2] == IDX_OUT_MODE
               || haddr[9:2] == IDX_SYNC_STATUS);
  // Track phases, expected bytes and pin silence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_rd <= 1'b0;
      dp_wr <= 1'b0;
      dp_hit <= 1'b0;
      dp_idx <= 8'h00;
      exp_mode <= OUT_MODE_RESET;
      exp_ctrl <= SYNC_CTRL_RESET;
      mode_age <= 2'h3;
      ctrl_age <= 2'h3;
      frame_q <= 1'b0;
      quiet <= 0;
      last_pix <= '0;
    end else begin
      dp_rd <= take && !hwrite;
      dp_wr <= take && hwrite;
      dp_hit <= hit;
      dp_idx <= haddr[9:2];
      mode_age <= (mode_age == 2'h3) ? mode_age : mode_age + 2'h1;
      ctrl_age <= (ctrl_age == 2'h3) ? ctrl_age : ctrl_age + 2'h1;
      if (dp_wr && dp_hit && dp_idx == IDX_OUT_MODE) begin
        exp_mode <= hwdata[7:0];
        mode_age <= 2'h0;
      end
      if (dp_wr && dp_hit && dp_idx == IDX_SYNC_CTRL) begin
        exp_ctrl <= hwdata[7:0];
        ctrl_age <= 2'h0;
      end
      frame_q <= sync_inputs[SYNC_FRAME];
      if (sync_inputs[SYNC_FRAME] != frame_q) begin
        quiet <= 0;
      end else if (quiet < ACTIVITY_TIMEOUT + 100) begin
        quiet <= quiet + 1;
      end
      if (pixel_valid) begin
        last_pix <= pixel_in;
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ========================================
  // Properties
  // ========================================
  sequence s_emit;
    port_a == last_pix && !pixel_output_clock ##1 pixel_output_clock;
  endsequence
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  property p_rd_unmapped;
    dp_rd && !dp_hit |-> hrdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  property p_rd_mode;
    dp_rd && dp_hit && dp_idx == IDX_OUT_MODE |-> hrdata == {24'h0, exp_mode};
  endproperty
  a_rd_mode: assert property (p_rd_mode)
    else $error("mode read back wrong");
  property p_chan;
    mode_age >= 2'h2 |-> analog_channel_select == exp_mode[MODE_CHANNEL];
  endproperty
  a_chan: assert property (p_chan) else $error("channel pin wrong");
  property p_bw;
    mode_age >= 2'h2 |-> analog_bandwidth_code == exp_mode[2:1];
  endproperty
  a_bw: assert property (p_bw) else $error("bandwidth pins wrong");
  property p_ext;
    mode_age >= 2'h2 |-> external_pixel_clock_select == exp_mode[0];
  endproperty
  a_ext: assert property (p_ext) else $error("clock source wrong");
  property p_single_b;
    mode_age >= 2'h2 && !exp_mode[MODE_DUAL_PORT] |-> port_b_oe == 3'h0;
  endproperty
  a_single_b: assert property (p_single_b)
    else $error("port b driven in single mode");
  property p_blue;
    mode_age >= 2'h2 && exp_mode[MODE_FMT_422]
      |-> !port_a_oe.b && !port_b_oe.b;
  endproperty
  a_blue: assert property (p_blue) else $error("blue lanes driven");
  property p_single_emit;
    pixel_valid && mode_age >= 2'h2 && !exp_mode[7] && !exp_mode[4]
      |=> ##[0:1] s_emit;
  endproperty
  a_single_emit: assert property (p_single_emit)
    else $error("single port sample not emitted");
  property p_line_ovr;
    exp_ctrl[4] && ctrl_age >= 2'h2 |-> active_line_sync_source == exp_ctrl[3];
  endproperty
  a_line_ovr: assert property (p_line_ovr)
    else $error("line source override ignored");
  property p_frame_ovr;
    exp_ctrl[1] && ctrl_age >= 2'h2
      |-> active_frame_sync_source == exp_ctrl[0];
  endproperty
  a_frame_ovr: assert property (p_frame_ovr)
    else $error("frame source override ignored");
  property p_frame_idle;
    !exp_ctrl[1] && ctrl_age >= 2'h2 && quiet > ACTIVITY_TIMEOUT + 12
      |-> active_frame_sync_source;
  endproperty
  a_frame_idle: assert property (p_frame_idle)
    else $error("idle frame pin still selected");
endmodule
bind ssom_sync_mode_ctrl ssom_chk #(.ACTIVITY_TIMEOUT(ACTIVITY_TIMEOUT))
  ssom_chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .sync_inputs(sync_inputs), .pixel_in(pixel_in),
  .pixel_valid(pixel_valid), .port_a(port_a), .port_a_oe(port_a_oe),
  .port_b_oe(port_b_oe), .pixel_output_clock(pixel_output_clock),
  .active_line_sync_source(active_line_sync_source),
  .active_frame_sync_source(active_frame_sync_source),
  .analog_channel_select(analog_channel_select),
  .analog_bandwidth_code(analog_bandwidth_code),
  .external_pixel_clock_select(external_pixel_clock_select));

// ===== ssom_pkg.sv
package ssom_pkg;

  // ==========================================================
  // Register map: printed indices, byte address is four times
  // ==========================================================
  localparam logic [7:0] IDX_SYNC_CTRL   = 8'h0e; // Sync source control
  localparam logic [7:0] IDX_SYNC_STATUS = 8'h14; // Sync detect status
  localparam logic [7:0] IDX_OUT_MODE    = 8'h15; // Output mode control
  localparam logic [7:0] SYNC_CTRL_RESET = 8'h00; // Auto select, no override
  localparam logic [7:0] OUT_MODE_RESET  = 8'hc0; // Dual port, parallel
  localparam logic [2:0] HSIZE_WORD      = 3'h2;  // Only word access
  localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;  // Transfer request

  // ==========================================================
  // Field positions
  // ==========================================================
  // Sync source control
  localparam int CTRL_LINE_OVERRIDE = 4;
  localparam int CTRL_LINE_SELECT   = 3;
  localparam int CTRL_FRAME_OVERRIDE = 1;
  localparam int CTRL_FRAME_SELECT  = 0;
  // Sync detect status
  localparam int ST_LINE_ACTIVE  = 7;
  localparam int ST_LINE_SOURCE  = 6;
  localparam int ST_LINE_POL     = 5;
  localparam int ST_FRAME_ACTIVE = 4;
  localparam int ST_FRAME_SOURCE = 3;
  localparam int ST_FRAME_POL    = 2;
  localparam int ST_GREEN_ACTIVE = 1;
  localparam int ST_HOLD_POL     = 0;
  // Output mode control
  localparam int MODE_DUAL_PORT  = 7;
  localparam int MODE_PARALLEL   = 6;
  localparam int MODE_SWAP       = 5;
  localparam int MODE_FMT_422    = 4;
  localparam int MODE_CHANNEL    = 3;
  localparam int MODE_BW_HI      = 2;
  localparam int MODE_BW_LO      = 1;
  localparam int MODE_EXT_CLOCK  = 0;

  // ==========================================================
  // Sync inputs and timing
  // ==========================================================
  localparam int SYNC_LINE  = 0; // Dedicated line sync pin
  localparam int SYNC_GREEN = 1; // Green embedded sync pin
  localparam int SYNC_FRAME = 2; // Frame sync pin
  localparam int SYNC_HOLD  = 3; // PLL hold pin
  localparam int NUM_SYNC   = 4;
  localparam int CNT_W      = 22; // Run length counter width
  localparam int ACT_TIMEOUT_MS = 40;    // Silence before inactive
  localparam int CLK_FREQ_KHZ   = 50000; // hclk rate
  localparam int ACT_TIMEOUT_CYCLES = ACT_TIMEOUT_MS * CLK_FREQ_KHZ;

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } ssom_pixel_t;

  typedef struct packed {
    logic r;
    logic g;
    logic b;
  } ssom_lane_oe_t;

  typedef struct packed {
    logic             level;    // Filtered pin level
    logic             active;   // Transitions seen recently
    logic [CNT_W-1:0] run;      // Cycles since last change
    logic [CNT_W-1:0] high_len; // Last high run
    logic [CNT_W-1:0] low_len;  // Last low run
  } ssom_det_t;

endpackage

// ===== ssom_sync_mode_ctrl.sv
`timescale 1ns/1ns
module ssom_sync_mode_ctrl #(
  parameter int ACTIVITY_TIMEOUT = ssom_pkg::ACT_TIMEOUT_CYCLES
) (
  input  wire  logic                   hclk,
  input  wire  logic                   hresetn,
  input  wire  logic                   hsel,
  input  wire  logic [31:0]            haddr,
  input  wire  logic [1:0]             htrans,
  input  wire  logic                   hwrite,
  input  wire  logic [2:0]             hsize,
  input  wire  logic [31:0]            hwdata,
  input  wire  logic                   hready,
  output logic [31:0]                  hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire  logic [ssom_pkg::NUM_SYNC-1:0] sync_inputs,
  input  wire  ssom_pkg::ssom_pixel_t  pixel_in,
  input  wire  logic                   pixel_valid,
  output ssom_pkg::ssom_pixel_t        port_a,
  output ssom_pkg::ssom_lane_oe_t      port_a_oe,
  output ssom_pkg::ssom_pixel_t        port_b,
  output ssom_pkg::ssom_lane_oe_t      port_b_oe,
  output logic                         pixel_output_clock,
  output logic                         active_line_sync_source,
  output logic                         active_frame_sync_source,
  output logic                         analog_channel_select,
  output logic [1:0]                   analog_bandwidth_code,
  output logic                         external_pixel_clock_select
);
  import ssom_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [NUM_SYNC-1:0] sync1;      // Synchroniser stage one
    logic [NUM_SYNC-1:0] sync2;      // Synchroniser stage two
    logic [NUM_SYNC-1:0] sync3;      // Synchroniser stage three
    ssom_det_t [NUM_SYNC-1:0] det;   // Per input detectors
    logic [7:0]   sync_ctrl;         // Sync source control
    logic [7:0]   out_mode;          // Output mode control
    logic         line_src;          // Active line sync source
    logic         frame_src;         // Active frame sync source
    logic         ap_valid;          // Address phase taken
    logic         ap_write;          // Taken phase is a write
    logic [7:0]   ap_idx;            // Register index of phase
    logic [31:0]  rdata;             // Read data
    logic         odd;               // Next sample is odd
    logic         pair_half;         // First of a pair is held
    logic         chroma_u;          // Next chroma is blue input
    ssom_pixel_t  hold_a;            // Pending port A pixel
    ssom_pixel_t  hold_b;            // Pending port B pixel
    ssom_pixel_t  out_a;             // Port A data
    ssom_pixel_t  out_b;             // Port B data
    ssom_lane_oe_t oe_a;             // Port A lane enables
    ssom_lane_oe_t oe_b;             // Port B lane enables
    logic         oclk;              // Output data clock
    logic         oclk_rise;         // Raise clock next cycle
    logic         ready;             // Bus ready, held high
    logic         resp;              // Bus response, always OKAY
  } ssom_state_t;

  ssom_state_t s;      // Registered state
  ssom_state_t next_s; // Next state

  // ==========================================================
  // Functions
  // ==========================================================
  // True when the index names a mapped register
  // Anything else reads zero and drops writes
  function automatic logic reg_mapped(input logic [7:0] idx);
    reg_mapped = (idx == IDX_SYNC_CTRL) || (idx == IDX_SYNC_STATUS) ||
                 (idx == IDX_OUT_MODE);
  endfunction

  // 4:2:2 packing of one sample
  function automatic ssom_pixel_t pack_sample(input ssom_pixel_t px,
                                              input logic fmt422,
                                              input logic use_u);
    pack_sample = px;
    if (fmt422) begin
      // Chroma alternates on red, blue lanes carry nothing
      pack_sample.r = use_u ? px.b : px.r;
      pack_sample.b = 8'h00;
    end
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    logic [NUM_SYNC-1:0] change;
    logic                line_on;
    logic                green_on;
    logic                line_pos;
    logic [7:0]          status;
    logic                line_lead;
    logic                to_a;
    logic                fmt422;
    logic                use_u;
    logic                emit;
    ssom_pixel_t         sample;
    change    = '0;
    line_on   = 1'b0;
    green_on  = 1'b0;
    line_pos  = 1'b0;
    status    = 8'h00;
    line_lead = 1'b0;
    to_a      = 1'b0;
    fmt422    = 1'b0;
    use_u     = 1'b0;
    emit      = 1'b0;
    sample    = '0;
    next_s    = s;

    // Three stage synchronisers, a change counts when 2 and 3 agree
    // Needing two stages to agree filters one cycle glitches
    next_s.sync1 = sync_inputs;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    for (int i = 0; i < NUM_SYNC; i++) begin
      change[i] = (s.sync2[i] == s.sync3[i]) && (s.sync3[i] != s.det[i].level);
      if (change[i]) begin
        // Close the run and record its length by level
        next_s.det[i].level  = s.sync3[i];
        next_s.det[i].active = 1'b1;
        next_s.det[i].run    = '0;
        if (s.det[i].level) begin
          next_s.det[i].high_len = s.det[i].run;
        end else begin
          next_s.det[i].low_len = s.det[i].run;
        end
      end else begin
        // Saturating run counter, silence drops activity
        // Saturation keeps a stuck pin from wrapping into a run
        if (s.det[i].run != '1) begin
          next_s.det[i].run = s.det[i].run + 1'b1;
        end
        if (s.det[i].run >= CNT_W'(ACTIVITY_TIMEOUT)) begin
          next_s.det[i].active = 1'b0;
        end
      end
    end

    line_on  = s.det[SYNC_LINE].active;
    green_on = s.det[SYNC_GREEN].active;
    // Short high run means a positive going pulse
    // Equal runs, none measured yet included, read negative
    line_pos = s.det[SYNC_LINE].high_len < s.det[SYNC_LINE].low_len;

    if (s.sync_ctrl[CTRL_LINE_OVERRIDE]) begin
      next_s.line_src = s.sync_ctrl[CTRL_LINE_SELECT];
    end else if (line_on && !green_on) begin
      next_s.line_src = 1'b0;
    end else if (green_on && !line_on) begin
      next_s.line_src = 1'b1;
    end else begin
      next_s.line_src = s.sync_ctrl[CTRL_LINE_SELECT];
    end

    if (s.sync_ctrl[CTRL_FRAME_OVERRIDE]) begin
      next_s.frame_src = s.sync_ctrl[CTRL_FRAME_SELECT];
    end else begin
      next_s.frame_src = !s.det[SYNC_FRAME].active;
    end

    // Status byte from live detector state
    // line sync activity
    status[ST_LINE_ACTIVE]  = line_on;
    status[ST_LINE_SOURCE]  = s.line_src;
    status[ST_LINE_POL]     = line_pos;
    status[ST_FRAME_ACTIVE] = s.det[SYNC_FRAME].active;
    status[ST_FRAME_SOURCE] = s.frame_src;
    // long high run reads active low
    status[ST_FRAME_POL]    = !(s.det[SYNC_FRAME].high_len <
                                s.det[SYNC_FRAME].low_len);
    status[ST_GREEN_ACTIVE] = green_on;
    status[ST_HOLD_POL]     = s.det[SYNC_HOLD].high_len <
                              s.det[SYNC_HOLD].low_len;

    // Data phase of a taken write
    if (s.ap_valid && s.ap_write) begin
      case (s.ap_idx)
        IDX_SYNC_CTRL: begin
          next_s.sync_ctrl = hwdata[7:0];
        end
        IDX_OUT_MODE: begin
          next_s.out_mode = hwdata[7:0];
        end
        default: begin
          next_s.out_mode = next_s.out_mode;
        end
      endcase
    end

    // Address phase, zero wait states, reads see pending write
    // Next values are read so a write just ahead reads back new
    // Refused accesses are still answered OKAY, with zero data
    next_s.ap_valid = hsel && hready && (htrans == HTRANS_NONSEQ) &&
                      (hsize == HSIZE_WORD) && (haddr[1:0] == 2'h0) &&
                      (haddr[31:10] == 22'h0) && reg_mapped(haddr[9:2]);
    next_s.ap_write = hwrite;
    next_s.ap_idx   = haddr[9:2];
    next_s.rdata    = 32'h0;
    if (next_s.ap_valid && !hwrite) begin
      case (haddr[9:2])
        IDX_SYNC_CTRL: begin
          next_s.rdata = {24'h0, next_s.sync_ctrl};
        end
        IDX_SYNC_STATUS: begin
          next_s.rdata = {24'h0, status};
        end
        IDX_OUT_MODE: begin
          next_s.rdata = {24'h0, next_s.out_mode};
        end
        default: begin
          next_s.rdata = 32'h0;
        end
      endcase
    end

    // Leading edge of the selected line sync
    // Restarting parity here drops any half built pair
    if (s.line_src) begin
      // Embedded sync is negative going
      line_lead = change[SYNC_GREEN] && !s.sync3[SYNC_GREEN];
    end else begin
      line_lead = change[SYNC_LINE] && (s.sync3[SYNC_LINE] == line_pos);
    end
    if (line_lead) begin
      next_s.odd       = 1'b1;
      next_s.pair_half = 1'b0;
      next_s.chroma_u  = 1'b1;
    end

    fmt422 = s.out_mode[MODE_FMT_422];

    // Steer one sample
    // Samples must arrive at least two cycles apart
    if (pixel_valid) begin
      use_u  = next_s.chroma_u;
      sample = pack_sample(pixel_in, fmt422, use_u);
      next_s.chroma_u = !use_u;
      // odd samples to A unless swapped
      to_a = next_s.odd ^ s.out_mode[MODE_SWAP];
      next_s.odd = !next_s.odd;
      if (!s.out_mode[MODE_DUAL_PORT]) begin
        next_s.out_a = sample;
        emit = 1'b1;
      end else if (s.out_mode[MODE_PARALLEL]) begin
        if (to_a) begin
          next_s.hold_a = sample;
        end else begin
          next_s.hold_b = sample;
        end
        if (next_s.pair_half) begin
          next_s.out_a = next_s.hold_a;
          next_s.out_b = next_s.hold_b;
          emit = 1'b1;
        end
        next_s.pair_half = !next_s.pair_half;
      end else begin
        if (to_a) begin
          next_s.out_a = sample;
        end else begin
          next_s.out_b = sample;
        end
        emit = 1'b1;
      end
    end

    // Output clock low with new data, high one cycle later
    // Capture must latch on the rising edge, data is settled then
    if (emit) begin
      next_s.oclk      = 1'b0;
      next_s.oclk_rise = 1'b1;
    end else if (s.oclk_rise) begin
      next_s.oclk      = 1'b1;
      next_s.oclk_rise = 1'b0;
    end

    // Lane enables; port B released in single port mode
    // Released lanes float at the pins, capture shows the inverse of its last value
    // blue lanes off in 4:2:2
    next_s.oe_a.r = 1'b1;
    next_s.oe_a.g = 1'b1;
    next_s.oe_a.b = !fmt422;
    next_s.oe_b.r = s.out_mode[MODE_DUAL_PORT];
    next_s.oe_b.g = s.out_mode[MODE_DUAL_PORT];
    next_s.oe_b.b = s.out_mode[MODE_DUAL_PORT] && !fmt422;

    // Every register answers at once, so the bus never waits
    next_s.ready = 1'b1;
    next_s.resp  = 1'b0;
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s           <= '0;
      s.sync_ctrl <= SYNC_CTRL_RESET;
      s.out_mode  <= OUT_MODE_RESET;
      s.odd       <= 1'b1;
      s.chroma_u  <= 1'b1;
      s.ready     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs, all straight from state
  // ==========================================================
  assign hrdata                   = s.rdata;
  assign hreadyout                = s.ready;
  assign hresp                    = s.resp;
  assign port_a                   = s.out_a;
  assign port_b                   = s.out_b;
  assign port_a_oe                = s.oe_a;
  assign port_b_oe                = s.oe_b;
  assign pixel_output_clock       = s.oclk;
  assign active_line_sync_source  = s.line_src;
  assign active_frame_sync_source = s.frame_src;
  assign analog_channel_select    = s.out_mode[MODE_CHANNEL];
  assign analog_bandwidth_code    = s.out_mode[MODE_BW_HI:MODE_BW_LO];
  assign external_pixel_clock_select = s.out_mode[MODE_EXT_CLOCK];

endmodule

// ===== testbench.sv
`timescale 1ns/1ns
module testbench;
  import ssom_pkg::*;
  `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
  localparam logic [31:0] A_CTRL = {22'h0, IDX_SYNC_CTRL, 2'h0};
  localparam logic [31:0] A_STAT = {22'h0, IDX_SYNC_STATUS, 2'h0};
  localparam logic [31:0] A_MODE = {22'h0, IDX_OUT_MODE, 2'h0};
  localparam logic [7:0] MODES [6] =
    '{8'h40, 8'h50, 8'hc0, 8'he0, 8'h80, 8'ha0}; // Mode loop bytes
  logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp, pvalid;
  logic [31:0]   haddr, hwdata, hrdata, rdata;
  logic [1:0]    htrans, bw;
  logic [2:0]    hsize;
  logic [3:0]    sync_inputs, base;
  logic          pclk, lsrc, fsrc, chan, ext;
  logic [7:0]    m, v;
  ssom_pixel_t   pixel_in, port_a, port_b, cap_a, cap_b, p1, p2;
  ssom_lane_oe_t port_a_oe, port_b_oe;
  int            caps, n0, num_errors, n_tests;
  ssom_sync_mode_ctrl #(.ACTIVITY_TIMEOUT(64)) ssom_sync_mode_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sync_inputs(sync_inputs), .pixel_in(pixel_in),
    .pixel_valid(pvalid), .port_a(port_a), .port_a_oe(port_a_oe),
    .port_b(port_b), .port_b_oe(port_b_oe), .pixel_output_clock(pclk),
    .active_line_sync_source(lsrc), .active_frame_sync_source(fsrc),
    .analog_channel_select(chan), .analog_bandwidth_code(bw),
    .external_pixel_clock_select(ext));
  ssom_capture ssom_capture_i (.pixel_output_clock(pclk), .port_a(port_a),
    .port_a_oe(port_a_oe), .port_b(port_b), .port_b_oe(port_b_oe),
    .cap_a(cap_a), .cap_b(cap_b), .caps(caps));
  always #10 hclk = ~hclk;
  // ========================================
  // Bus, sync and pixel drivers
  // ========================================
  task bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask
  task rd(input logic [31:0] a, input logic [7:0] msk, e);
    bus(1'b0, a, 32'h0);
    `CHK(rdata & {24'hffffff, msk}, {24'h0, e})
  endtask
  // Short pulses on the masked pins around the base levels
  task burst(input logic [3:0] msk, input int n);
    repeat (n) begin
      sync_inputs <= base ^ msk;
      repeat (4) @(posedge hclk);
      sync_inputs <= base;
      repeat (16) @(posedge hclk);
    end
  endtask
  task pix(input ssom_pixel_t p);
    pixel_in <= p;
    pvalid <= 1'b1;
    @(posedge hclk);
    pvalid <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  task summarize;
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge hclk);
    num_errors++;
    summarize();
  end
  // ========================================
  // Scenarios
  // ========================================
  initial begin
    {hclk, hresetn, hsel, hwrite, pvalid} = 5'h0;
    {haddr, hwdata, htrans, sync_inputs, base} = '0;
    hsize = HSIZE_WORD;
    pixel_in = '0;
    num_errors = 0;
    n_tests = 0;
    p1 = 24'h112233;
    p2 = 24'h445566;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (80) @(posedge hclk);
    rd(A_CTRL, 8'h1b, 8'h00);
    rd(A_MODE, 8'hc1, 8'hc0);
    rd(A_STAT, 8'hff, 8'h0c);
    bus(1'b1, A_STAT, 32'hff);
    rd(A_STAT, 8'hff, 8'h0c);
    rd(32'h40, 8'hff, 8'h00);
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, A_MODE, {24'h0, 4'hc, i[3:0]});
      repeat (2) @(posedge hclk);
      `CHK({chan, bw, ext}, i[3:0])
    end
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'h1b : 8'h12;
      bus(1'b1, A_CTRL, {24'h0, v});
      repeat (2) @(posedge hclk);
      `CHK({lsrc, fsrc}, {v[3], v[0]})
      rd(A_STAT, 8'h48, {1'b0, v[3], 2'h0, v[0], 3'h0});
    end
    bus(1'b1, A_CTRL, 32'h0);
    base = 4'b0100;
    burst(4'hf, 6);
    rd(A_STAT, 8'hff, 8'hb7);
    bus(1'b1, A_CTRL, 32'h08);
    rd(A_STAT, 8'h40, 8'h40);
    bus(1'b1, A_CTRL, 32'h0);
    burst(4'b0010, 8);
    rd(A_STAT, 8'hda, 8'h4a);
    bus(1'b1, A_CTRL, 32'h08);
    burst(4'b0001, 8);
    rd(A_STAT, 8'hda, 8'h88);
    bus(1'b1, A_CTRL, 32'h10);
    for (int j = 0; j < 6; j++) begin
      m = MODES[j];
      bus(1'b1, A_MODE, {24'h0, m});
      burst(4'b0001, 1);
      n0 = caps;
      pix(p1);
      if (m == 8'h50) `CHK({cap_a.r, cap_a.g}, {p1.b, p1.g})
      pix(p2);
      if (m[7]) `CHK({cap_a, cap_b}, m[5] ? {p2, p1} : {p1, p2})
      else `CHK({cap_a.r, cap_a.g, port_a_oe.b}, {p2.r, p2.g, !m[4]})
      `CHK(port_b_oe, m[7] ? 3'h7 : 3'h0)
      `CHK(caps - n0, (m[7] && m[6]) ? 1 : 2)
    end
    summarize();
  end
endmodule
